// ### rtl/cabe_alu.sv
// combinational alu for add-with-carry, and, and bit clear
`timescale 1ns/1ps
`default_nettype none
`include "cabe_consts.svh"
module cabe_alu
(
  // operands in, result and flags out
  cabe_alu_if.alu bus
);

  // untouched flags pass through so callers may commit all five
  always_comb
  begin
    logic [8:0] sum;
    logic [4:0] low;
    logic [7:0] res;
    logic [4:0] f;
    sum = 9'h000;
    low = 5'h00;
    res = bus.opnd;
    f   = bus.flags_in;
    case (bus.op)
      cabe_pkg::OP_ADDC:
      begin
        sum = {1'b0, bus.acc} + {1'b0, bus.opnd}
              + {8'h00, bus.flags_in[`CABE_ST_C]};
        low = {1'b0, bus.acc[3:0]} + {1'b0, bus.opnd[3:0]}
              + {4'h0, bus.flags_in[`CABE_ST_C]};
        res = sum[7:0];
        f[`CABE_ST_C]  = sum[8];
        f[`CABE_ST_DCY] = low[4];
        f[`CABE_ST_OVF] = (bus.acc[7] == bus.opnd[7])
                          && (res[7] != bus.acc[7]);
        f[`CABE_ST_N]  = res[7];
        f[`CABE_ST_Z]  = (res == 8'h00);
      end
      cabe_pkg::OP_ANDF, cabe_pkg::OP_ANDL:
      begin
        res = bus.acc & ((bus.op == cabe_pkg::OP_ANDL) ?
                         bus.lit : bus.opnd);
        f[`CABE_ST_N] = res[7];
        f[`CABE_ST_Z] = (res == 8'h00);
      end
      cabe_pkg::OP_BCLR:
      begin
        res = bus.opnd & ~(8'h01 << bus.bitsel);
      end
      default:
      begin
        res = bus.opnd;
      end
    endcase
    bus.result    = res;
    bus.flags_out = f;
  end

endmodule // cabe_alu
`default_nettype wire

// ### rtl/cabe_alu_if.sv
// carrier between the executor and its alu
`timescale 1ns/1ps
`default_nettype none
interface cabe_alu_if;
  cabe_pkg::cabe_op_t op;
  logic [7:0]         acc;
  logic [7:0]         opnd;
  logic [7:0]         lit;
  logic [2:0]         bitsel;
  logic [4:0]         flags_in;
  logic [7:0]         result;
  logic [4:0]         flags_out;

  modport alu (input op, acc, opnd, lit, bitsel, flags_in,
               output result, flags_out);
  modport core (output op, acc, opnd, lit, bitsel, flags_in,
                input result, flags_out);
endinterface
`default_nettype wire

// ### rtl/cabe_consts.svh
// constant offsets, field positions, opcodes and reset values for cabe
`ifndef CABE_CONSTS_SVH
`define CABE_CONSTS_SVH

// register byte offsets on the avalon-mm slave
`define CABE_OFF_CTRL    8'h00
`define CABE_OFF_INSTR   8'h04
`define CABE_OFF_ACC     8'h08
`define CABE_OFF_STATUS  8'h0C
`define CABE_OFF_BANK    8'h10
`define CABE_OFF_INDEX   8'h14
`define CABE_OFF_PC      8'h18
`define CABE_OFF_MADDR   8'h1C
`define CABE_OFF_MDATA   8'h20
`define CABE_OFF_CYCLES  8'h24

// field positions
`define CABE_CTRL_EXT    0
`define CABE_ST_C        0
`define CABE_ST_DCY      1
`define CABE_ST_Z        2
`define CABE_ST_OVF      3
`define CABE_ST_N        4
`define CABE_ST_BUSY     8
`define CABE_IW_DEST     9
`define CABE_IW_BANK     8

// opcode patterns
`define CABE_OPC_ADDC    6'h08
`define CABE_OPC_ANDF    6'h05
`define CABE_OPC_ANDL    8'h0B
`define CABE_OPC_BRC     8'hE2
`define CABE_OPC_BRN     8'hE6
`define CABE_OPC_BCLR    4'h9

// addressing
`define CABE_ACCESS_LIM  8'h5F
`define CABE_SFR_PAGE    4'hF
`define CABE_LOW_PAGE    4'h0

// timing and reset values
`define CABE_PC_STEP     16'h0002
`define CABE_NOP_LAST    2'h3
`define CABE_CYC_ONE     2'h1
`define CABE_CYC_TWO     2'h2
`define CABE_RST_PC      16'h0000
`define CABE_RST_WAIT    1'b1

`endif

// ### rtl/cabe_core.sv
// cabe_core: avalon-mm slave running add/and/branch/bit-clear instructions
//
// The Avalon-MM interface to the registers and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "cabe_consts.svh"
module cabe_core
(
  // clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_resetn,
  // avalon-mm slave
  input  wire logic [7:0]  i_avs_address,
  input  wire logic        i_avs_read,
  input  wire logic        i_avs_write,
  input  wire logic [31:0] i_avs_writedata,
  output logic      [31:0] o_avs_readdata,
  output logic             o_avs_waitrequest
);

  cabe_pkg::cabe_regs_t r;
  cabe_pkg::cabe_regs_t n;

  // data memory, 16 banks of 256 bytes
  logic [7:0]  mem [0:4095];
  logic        mem_we;
  logic [11:0] mem_wa;
  logic [7:0]  mem_wd;

  logic [31:0] rd_word;
  logic        bus_wr;
  logic        br_taken;
  logic [15:0] br_target;
  logic [15:0] pc_next;

  cabe_alu_if alu_bus ();

  cabe_alu u_alu
  (
    .bus (alu_bus)
  );

  // decode the opcode word into an operation
  function automatic cabe_pkg::cabe_op_t decode(input logic [15:0] iw);
    cabe_pkg::cabe_op_t op;
    op = cabe_pkg::OP_NONE;
    if (iw[15:10] == `CABE_OPC_ADDC)
      op = cabe_pkg::OP_ADDC;
    else if (iw[15:10] == `CABE_OPC_ANDF)
      op = cabe_pkg::OP_ANDF;
    else if (iw[15:8] == `CABE_OPC_ANDL)
      op = cabe_pkg::OP_ANDL;
    else if (iw[15:8] == `CABE_OPC_BRC)
      op = cabe_pkg::OP_BRC;
    else if (iw[15:8] == `CABE_OPC_BRN)
      op = cabe_pkg::OP_BRN;
    else if (iw[15:12] == `CABE_OPC_BCLR)
      op = cabe_pkg::OP_BCLR;
    return op;
  endfunction

  // resolve an 8-bit file operand into a 12-bit data address
  function automatic logic [11:0] file_addr(input logic       a,
                                            input logic       ext,
                                            input logic [7:0] f,
                                            input logic [3:0] bank,
                                            input logic [11:0] idx);
    logic [11:0] fa;
    fa = {`CABE_LOW_PAGE, f};
    if (a)
      fa = {bank, f};
    else if (ext && (f <= `CABE_ACCESS_LIM))
      fa = idx + {4'h0, f};
    else if (f > `CABE_ACCESS_LIM)
      fa = {`CABE_SFR_PAGE, f};
    return fa;
  endfunction

  // alu sees the latched instruction and operand
  assign alu_bus.op       = r.op;
  assign alu_bus.acc      = r.acc;
  assign alu_bus.opnd     = r.opnd;
  assign alu_bus.lit      = r.instr[7:0];
  assign alu_bus.bitsel   = r.instr[11:9];
  assign alu_bus.flags_in = r.flags;

  // branch decision and relative target
  assign br_taken  = ((r.op == cabe_pkg::OP_BRC) && r.flags[`CABE_ST_C])
                  || ((r.op == cabe_pkg::OP_BRN)
                      && r.flags[`CABE_ST_N]);
  assign pc_next   = r.pc + `CABE_PC_STEP;
  assign br_target = pc_next + {{7{r.instr[7]}}, r.instr[7:0],
                                1'b0};
  assign bus_wr    = i_avs_write && !r.waitreq;

  // read mux; unmapped offsets answer zero
  always_comb
  begin
    rd_word = 32'h0000_0000;
    case (i_avs_address)
      `CABE_OFF_CTRL:   rd_word[`CABE_CTRL_EXT] = r.ext_en;
      `CABE_OFF_INSTR:  rd_word[15:0] = r.instr;
      `CABE_OFF_ACC:    rd_word[7:0] = r.acc;
      `CABE_OFF_STATUS:
      begin
        rd_word[4:0]          = r.flags;
        rd_word[`CABE_ST_BUSY] = (r.phase != cabe_pkg::P_IDLE);
      end
      `CABE_OFF_BANK:   rd_word[3:0] = r.bank;
      `CABE_OFF_INDEX:  rd_word[11:0] = r.index;
      `CABE_OFF_PC:     rd_word[15:0] = r.pc;
      `CABE_OFF_MADDR:  rd_word[11:0] = r.mem_addr;
      `CABE_OFF_MDATA:  rd_word[7:0] = mem[r.mem_addr];
      `CABE_OFF_CYCLES: rd_word[1:0] = r.cycles;
      default:          rd_word = 32'h0000_0000;
    endcase
  end

  // next state: bus handshake, phase sequencer, register writes
  always_comb
  begin
    n      = r;
    mem_we = 1'b0;
    mem_wa = r.faddr;
    mem_wd = alu_bus.result;
    // one wait cycle per access keeps read data registered
    if (!r.waitreq)
    begin
      n.waitreq = 1'b1;
    end
    else if (i_avs_read || i_avs_write)
    begin
      n.waitreq = 1'b0;
      n.rdata   = rd_word;
    end
    case (r.phase)
      cabe_pkg::P_IDLE:
      begin
        if (bus_wr && (i_avs_address == `CABE_OFF_INSTR))
        begin
          n.instr = i_avs_writedata[15:0];
          n.phase = cabe_pkg::P_DECODE;
        end
      end
      cabe_pkg::P_DECODE:
      begin
        n.op    = decode(r.instr);
        n.faddr = file_addr(r.instr[`CABE_IW_BANK], r.ext_en,
                            r.instr[7:0], r.bank, r.index);
        n.phase = cabe_pkg::P_READ;
      end
      cabe_pkg::P_READ:
      begin
        n.opnd  = mem[r.faddr];
        n.phase = cabe_pkg::P_PROC;
      end
      cabe_pkg::P_PROC:
      begin
        n.phase = cabe_pkg::P_WRITE;
      end
      cabe_pkg::P_WRITE:
      begin
        n.pc     = pc_next;
        n.cycles = `CABE_CYC_ONE;
        n.phase  = cabe_pkg::P_IDLE;
        case (r.op)
          cabe_pkg::OP_ADDC, cabe_pkg::OP_ANDF:
          begin
            n.flags = alu_bus.flags_out;
            if (r.instr[`CABE_IW_DEST])
              mem_we = 1'b1;
            else
              n.acc = alu_bus.result;
          end
          cabe_pkg::OP_ANDL:
          begin
            n.acc   = alu_bus.result;
            n.flags = alu_bus.flags_out;
          end
          cabe_pkg::OP_BCLR:
          begin
            mem_we = 1'b1;
          end
          cabe_pkg::OP_BRC, cabe_pkg::OP_BRN:
          begin
            // pc written in the fourth phase, then a dead cycle
            if (br_taken)
            begin
              n.pc      = br_target;
              n.cycles  = `CABE_CYC_TWO;
              n.nop_cnt = 2'h0;
              n.phase   = cabe_pkg::P_NOP;
            end
          end
          default:
          begin
            n.cycles = `CABE_CYC_ONE;
          end
        endcase
      end
      cabe_pkg::P_NOP:
      begin
        n.nop_cnt = r.nop_cnt + 2'h1;
        if (r.nop_cnt == `CABE_NOP_LAST)
          n.phase = cabe_pkg::P_IDLE;
      end
      default:
      begin
        n.phase = cabe_pkg::P_IDLE;
      end
    endcase
    // software writes only while idle, so no clash with execution
    if (bus_wr && (r.phase == cabe_pkg::P_IDLE))
    begin
      case (i_avs_address)
        `CABE_OFF_CTRL:   n.ext_en = i_avs_writedata[`CABE_CTRL_EXT];
        `CABE_OFF_ACC:    n.acc = i_avs_writedata[7:0];
        `CABE_OFF_STATUS: n.flags = i_avs_writedata[4:0];
        `CABE_OFF_BANK:   n.bank = i_avs_writedata[3:0];
        `CABE_OFF_INDEX:  n.index = i_avs_writedata[11:0];
        `CABE_OFF_PC:     n.pc = i_avs_writedata[15:0];
        `CABE_OFF_MADDR:  n.mem_addr = i_avs_writedata[11:0];
        `CABE_OFF_MDATA:
        begin
          mem_we = 1'b1;
          mem_wa = r.mem_addr;
          mem_wd = i_avs_writedata[7:0];
        end
        default:          n.ext_en = r.ext_en;
      endcase
    end
  end

  // state register
  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      r         <= '0;
      r.pc      <= `CABE_RST_PC;
      r.waitreq <= `CABE_RST_WAIT;
    end
    else
    begin
      r <= n;
    end
  end

  // data memory has no reset; contents are undefined at start
  always_ff @(posedge i_clk)
  begin
    if (mem_we)
      mem[mem_wa] <= mem_wd;
  end

  assign o_avs_readdata    = r.rdata;
  assign o_avs_waitrequest = r.waitreq;

  // checks
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_resetn);

  sequence s_commit(cabe_pkg::cabe_op_t op);
    (r.phase == cabe_pkg::P_WRITE) && (r.op == op);
  endsequence

  sequence s_dead_cycle;
    (r.phase == cabe_pkg::P_NOP) [*4] ##1 (r.phase == cabe_pkg::P_IDLE);
  endsequence

  AST_ADDC_SUM: assert property (
    s_commit(cabe_pkg::OP_ADDC) ##0 !r.instr[`CABE_IW_DEST]
    |=> r.acc == 8'($past(r.acc) + $past(r.opnd)
                    + {7'h00, $past(r.flags[`CABE_ST_C])}))
    else $error("add with carry gave a wrong sum");

  AST_DEST_FILE: assert property (
    (r.phase == cabe_pkg::P_WRITE) && r.instr[`CABE_IW_DEST]
    && ((r.op == cabe_pkg::OP_ADDC) || (r.op == cabe_pkg::OP_ANDF))
    |-> mem_we && (mem_wa == r.faddr) ##1 $stable(r.acc))
    else $error("file destination not written back");

  AST_BANKED_ADDR: assert property (
    (r.phase == cabe_pkg::P_READ) && r.instr[`CABE_IW_BANK]
    && (r.op != cabe_pkg::OP_NONE)
    |-> r.faddr == {r.bank, r.instr[7:0]})
    else $error("banked address not built from bank register");

  AST_INDEXED_ADDR: assert property (
    (r.phase == cabe_pkg::P_READ) && !r.instr[`CABE_IW_BANK]
    && r.ext_en && (r.instr[7:0] <= `CABE_ACCESS_LIM)
    |-> r.faddr == 12'(r.index + {4'h0, r.instr[7:0]}))
    else $error("indexed literal offset address wrong");

  AST_ANDF_FLAGS: assert property (
    s_commit(cabe_pkg::OP_ANDF)
    |=> $stable(r.flags[`CABE_ST_C]) && $stable(r.flags[`CABE_ST_DCY])
        && $stable(r.flags[`CABE_ST_OVF]))
    else $error("and with file changed carry or overflow");

  AST_BRC_FLAGS: assert property (
    s_commit(cabe_pkg::OP_BRC) |=> $stable(r.flags))
    else $error("branch on carry changed a flag");

  AST_BR_TARGET: assert property (
    (r.phase == cabe_pkg::P_WRITE) && br_taken
    |=> r.pc == 16'($past(r.pc) + 16'h0002
                    + {{7{$past(r.instr[7])}}, $past(r.instr[7:0]), 1'b0}))
    else $error("taken branch target wrong");

  AST_TAKEN_TWO: assert property (
    (r.phase == cabe_pkg::P_WRITE) && br_taken
    |=> s_dead_cycle ##0 (r.cycles == 2'h2))
    else $error("taken branch did not last two cycles");

  AST_UNTAKEN_ONE: assert property (
    s_commit(cabe_pkg::OP_BRN) ##0 !r.flags[`CABE_ST_N]
    |=> (r.phase == cabe_pkg::P_IDLE) && (r.cycles == 2'h1)
        && (r.pc == 16'($past(r.pc) + 16'h0002)))
    else $error("untaken branch on negative misbehaved");

  AST_ANDL_ACC: assert property (
    s_commit(cabe_pkg::OP_ANDL)
    |=> (r.acc == ($past(r.acc) & $past(r.instr[7:0])))
        && $stable(r.flags[`CABE_ST_C]))
    else $error("and literal result or flags wrong");

  AST_BIT_CLEAR: assert property (
    s_commit(cabe_pkg::OP_BCLR)
    |=> (mem[$past(r.faddr)][$past(r.instr[11:9])] == 1'b0)
        && $stable(r.flags))
    else $error("bit clear left bit set or moved a flag");

endmodule // cabe_core
`default_nettype wire

// ### rtl/cabe_pkg.sv
// types shared by the cabe executor and its alu
package cabe_pkg;

  // decoded operation
  typedef enum logic [2:0] {
    OP_NONE,
    OP_ADDC,
    OP_ANDF,
    OP_ANDL,
    OP_BRC,
    OP_BRN,
    OP_BCLR
  } cabe_op_t;

  // instruction phases, four clocks per instruction cycle
  typedef enum logic [2:0] {
    P_IDLE,
    P_DECODE,
    P_READ,
    P_PROC,
    P_WRITE,
    P_NOP
  } cabe_phase_t;

  // register state of the executor; the data memory is kept apart
  typedef struct packed {
    cabe_phase_t phase;
    logic [1:0]  nop_cnt;
    logic        ext_en;
    logic [15:0] instr;
    cabe_op_t    op;
    logic [7:0]  acc;
    logic [4:0]  flags;
    logic [3:0]  bank;
    logic [11:0] index;
    logic [15:0] pc;
    logic [11:0] mem_addr;
    logic [11:0] faddr;
    logic [7:0]  opnd;
    logic [1:0]  cycles;
    logic        waitreq;
    logic [31:0] rdata;
  } cabe_regs_t;

endpackage

// ### testbench/tb.sv
// self-checking bench for the cabe executor over its avalon-mm slave
`timescale 1ns/1ps
`default_nettype none
`include "cabe_consts.svh"
`define CHK(got, exp) \
  begin \
    comparisons++; \
    if ((got) !== (exp)) \
    begin \
      errors++; \
      $display("unexpected at %0t: got %h want %h", $time, got, exp); \
    end \
  end
module tb;
  // clock, reset and avalon-mm bus
  logic        clk;
  logic        resetn;
  logic [7:0]  address;
  logic        read;
  logic        write;
  logic [31:0] writedata;
  logic [31:0] readdata;
  logic        waitrequest;
  // bookkeeping
  int          errors;
  int          comparisons;
  logic [31:0] rv;

  cabe_core i_dut (
    .i_clk            (clk),
    .i_resetn         (resetn),
    .i_avs_address    (address),
    .i_avs_read       (read),
    .i_avs_write      (write),
    .i_avs_writedata  (writedata),
    .o_avs_readdata   (readdata),
    .o_avs_waitrequest(waitrequest)
  );

  // 250 mhz clock
  always #2 clk = ~clk;

  // verdict and end of run, also reached by any timeout
  task automatic report_and_stop();
    if (errors == 0 && comparisons > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // one avalon access; a leading edge keeps drives one per time step
  task automatic bus(input logic [7:0] a, input logic rw,
                     input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk);
    address   <= a;
    read      <= ~rw;
    write     <= rw;
    writedata <= d;
    do
    begin
      @(posedge clk);
      n++;
    end while (waitrequest !== 1'b0 && n < 50);
    q = readdata;
    read  <= 1'b0;
    write <= 1'b0;
    if (n >= 50)
    begin
      errors++;
      report_and_stop();
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(a, 1'b1, d, q);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] q);
    bus(a, 1'b0, 32'h0, q);
  endtask

  // data memory goes through the pointer and data window
  task automatic mem_wr(input logic [11:0] a, input logic [7:0] d);
    wr(`CABE_OFF_MADDR, {20'h0, a});
    wr(`CABE_OFF_MDATA, {24'h0, d});
  endtask

  task automatic mem_rd(input logic [11:0] a, output logic [31:0] q);
    wr(`CABE_OFF_MADDR, {20'h0, a});
    rd(`CABE_OFF_MDATA, q);
  endtask

  // poll busy under a bound; the first poll must still see it set
  task automatic wait_idle();
    logic [31:0] q;
    int          n;
    n = 0;
    rd(`CABE_OFF_STATUS, q);
    `CHK(q[8], 1'b1)
    while (q[8] !== 1'b0 && n < 20)
    begin
      rd(`CABE_OFF_STATUS, q);
      n++;
    end
    if (n >= 20)
    begin
      errors++;
      report_and_stop();
    end
  endtask

  task automatic exec(input logic [15:0] iw);
    wr(`CABE_OFF_INSTR, {16'h0, iw});
    wait_idle();
  endtask

  // acc, status and cycle count after one instruction
  task automatic chk_core(input logic [7:0] acc, input logic [4:0] st,
                          input logic [1:0] cyc);
    logic [31:0] q;
    rd(`CABE_OFF_ACC, q);
    `CHK(q, {24'h0, acc})
    rd(`CABE_OFF_STATUS, q);
    `CHK(q, {27'h0, st})
    rd(`CABE_OFF_CYCLES, q);
    `CHK(q, {30'h0, cyc})
  endtask

  // conditional branch from 0100h; flags must come back untouched
  task automatic branch(input logic [7:0] op, input logic [4:0] st,
                        input logic [7:0] n, input logic [15:0] pc,
                        input logic [1:0] cyc);
    logic [31:0] q;
    wr(`CABE_OFF_STATUS, {27'h0, st});
    wr(`CABE_OFF_PC, 32'h0000_0100);
    wr(`CABE_OFF_ACC, 32'h0000_003C);
    exec({op, n});
    rd(`CABE_OFF_PC, q);
    `CHK(q, {16'h0, pc})
    chk_core(8'h3C, st, cyc);
  endtask

  initial
  begin
    clk       = 1'b0;
    resetn    = 1'b0;
    address   = 8'h00;
    read      = 1'b0;
    write     = 1'b0;
    writedata = 32'h0;
    errors    = 0;
    comparisons = 0;
    repeat (12) @(posedge clk);
    `CHK(waitrequest, 1'b1)
    resetn <= 1'b1;
    // reset values, unmapped place reads zero and ignores writes
    chk_core(8'h00, 5'h00, 2'h0);
    rd(`CABE_OFF_PC, rv);
    `CHK(rv, 32'h0)
    wr(8'hFC, 32'hFFFF_FFFF);
    rd(8'hFC, rv);
    `CHK(rv, 32'h0)
    // add with carry from banked file into acc: 4D+02+1
    wr(`CABE_OFF_BANK, 32'h2);
    mem_wr(12'h210, 8'h02);
    wr(`CABE_OFF_ACC, 32'h4D);
    wr(`CABE_OFF_STATUS, 32'h01);
    exec(16'h2110);
    chk_core(8'h50, 5'h02, 2'h1);
    // add with carry back to file: 80+80 wraps, sets carry, zero, overflow
    mem_wr(12'h210, 8'h80);
    wr(`CABE_OFF_ACC, 32'h80);
    wr(`CABE_OFF_STATUS, 32'h00);
    exec(16'h2310);
    chk_core(8'h80, 5'h0D, 2'h1);
    mem_rd(12'h210, rv);
    `CHK(rv, 32'h00)
    // and with access-bank file above 5Fh, other flags kept
    mem_wr(12'hFC2, 8'hC2);
    wr(`CABE_OFF_ACC, 32'h17);
    wr(`CABE_OFF_STATUS, 32'h1F);
    exec(16'h14C2);
    chk_core(8'h02, 5'h0B, 2'h1);
    // indexed literal offset: index 100h plus 20h, result to file
    wr(`CABE_OFF_CTRL, 32'h1);
    wr(`CABE_OFF_INDEX, 32'h100);
    mem_wr(12'h120, 8'hF0);
    wr(`CABE_OFF_ACC, 32'h9F);
    exec(16'h1620);
    mem_rd(12'h120, rv);
    `CHK(rv, 32'h90)
    chk_core(8'h9F, 5'h1B, 2'h1);
    wr(`CABE_OFF_CTRL, 32'h0);
    // and literal giving zero
    wr(`CABE_OFF_ACC, 32'h55);
    exec(16'h0B0A);
    chk_core(8'h00, 5'h0F, 2'h1);
    // bit clear of bit 7 in banked file, flags untouched
    mem_wr(12'h210, 8'hC7);
    wr(`CABE_OFF_STATUS, 32'h15);
    exec(16'h9F10);
    mem_rd(12'h210, rv);
    `CHK(rv, 32'h47)
    chk_core(8'h00, 5'h15, 2'h1);
    // branches: taken forward, taken most negative, not taken
    branch(8'hE2, 5'h01, 8'h05, 16'h010C, 2'h2);
    branch(8'hE2, 5'h01, 8'h80, 16'h0002, 2'h2);
    branch(8'hE2, 5'h1E, 8'h05, 16'h0102, 2'h1);
    branch(8'hE6, 5'h10, 8'h7F, 16'h0200, 2'h2);
    branch(8'hE6, 5'h0F, 8'h05, 16'h0102, 2'h1);
    // writes while a taken branch runs, one in its nop cycle, are ignored
    wr(`CABE_OFF_STATUS, 32'h01);
    wr(`CABE_OFF_ACC, 32'h11);
    wr(`CABE_OFF_INSTR, 32'hE205);
    wr(`CABE_OFF_ACC, 32'h22);
    wr(`CABE_OFF_STATUS, 32'h1E);
    wait_idle();
    chk_core(8'h11, 5'h01, 2'h2);
    // an opcode outside the set only steps the pc, in one cycle
    wr(`CABE_OFF_PC, 32'h0000_0100);
    exec(16'hFFFF);
    rd(`CABE_OFF_PC, rv);
    `CHK(rv, 32'h0000_0102)
    chk_core(8'h11, 5'h01, 2'h1);
    report_and_stop();
  end
endmodule // tb
`default_nettype wire
